// ===== input_capture_pkg.sv
package input_capture_pkg;

    // register byte addresses
    localparam logic [7:0] ADDR_CONTROL_ONE = 8'h00;
    localparam logic [7:0] ADDR_CONTROL_TWO = 8'h04;
    localparam logic [7:0] ADDR_BUFFER = 8'h08;

    localparam logic [15:0] CONTROL_ONE_RESET = 16'h0000;
    localparam logic [15:0] CONTROL_TWO_RESET = 16'h0000;
    localparam logic [15:0] CONTROL_ONE_WMASK = 16'h3C67;
    localparam logic [15:0] CONTROL_TWO_WMASK = 16'h01DF;

    // capture mode codes
    localparam logic [2:0] MODE_OFF = 3'h0;
    localparam logic [2:0] MODE_EVERY_EDGE = 3'h1;
    localparam logic [2:0] MODE_FALLING = 3'h2;
    localparam logic [2:0] MODE_RISING = 3'h3;
    localparam logic [2:0] MODE_RISE_DIV4 = 3'h4;
    localparam logic [2:0] MODE_RISE_DIV16 = 3'h5;
    localparam logic [2:0] MODE_UNUSED = 3'h6;
    localparam logic [2:0] MODE_WAKE_PIN = 3'h7;

    // time base codes
    localparam logic [2:0] TB_LAST_TIMER = 3'h4;
    localparam logic [2:0] TB_SYSTEM_CLOCK = 3'h7;

    localparam logic [4:0] SYNC_NONE = 5'h00;
    localparam logic [3:0] PRESCALE_DIV4_LAST = 4'h3;
    localparam logic [3:0] PRESCALE_DIV16_LAST = 4'hF;

    typedef struct packed {
        logic [1:0] unused_hi;
        logic idle_stop;
        logic [2:0] time_base_select;
        logic [2:0] unused_mid;
        logic [1:0] captures_per_interrupt;
        logic buffer_overflow_flag;
        logic buffer_not_empty;
        logic [2:0] capture_mode_select;
    } control_one_t;

    typedef struct packed {
        logic [6:0] unused_hi;
        logic cascade_enable;
        logic trigger_mode_select;
        logic trigger_run_status;
        logic unused_5;
        logic [4:0] sync_source_select;
    } control_two_t;

    typedef enum logic [1:0] {
        OP_FREE,
        OP_SYNC,
        OP_TRIGGER,
        OP_SOFT_TRIGGER
    } op_mode_t;

endpackage

// ===== input_capture_unit.sv
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ps

module input_capture_unit #(
    parameter int COUNTER_WIDTH = 16,
    parameter int FIFO_DEPTH = 4,
    parameter bit EVEN_MODULE = 1'b0
) (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // capture pin and time bases
    input wire logic capture_input_pin,
    input wire logic [4:0] timer_tick,
    // sync and trigger sources
    input wire logic [31:0] sync_event,
    input wire logic [31:0] sync_source_on,
    // processor power state
    input wire logic cpu_idle,
    input wire logic cpu_sleep,
    // cascade partner
    input wire logic carry_in,
    input wire logic partner_capture,
    input wire logic partner_run,
    output logic carry_out,
    output logic capture_strobe,
    output logic run_out,
    // interrupt
    output logic capture_irq
);

    localparam int PTR_W = $clog2(FIFO_DEPTH);
    localparam int CNT_W = $clog2(FIFO_DEPTH + 1);
    localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(FIFO_DEPTH);
    localparam logic [COUNTER_WIDTH-1:0] ALL_ONES = '1;

    input_capture_pkg::control_one_t control_one;
    input_capture_pkg::control_two_t control_two;
    input_capture_pkg::op_mode_t op_mode;
    logic [COUNTER_WIDTH-1:0] capture_counter;
    logic [COUNTER_WIDTH-1:0] fifo_mem [FIFO_DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] fill;
    logic overflow;
    logic pin_meta;
    logic pin_sync;
    logic pin_prev;
    logic [3:0] prescale;
    logic [1:0] event_count;
    logic rise;
    logic fall;
    logic cascade_even;
    logic trig_eff;
    logic sel_sync;
    logic tick;
    logic inc;
    logic gate;
    logic halted;
    logic active;
    logic edge_hit;
    logic capture_now;
    logic push;
    logic pop;
    logic apb_setup;
    logic apb_write;
    logic mapped;

    // time base tick for the selected code
    function automatic logic base_tick(input logic [2:0] sel, input logic [4:0] ticks);
        logic t;
        t = 1'b0;
        if (sel == input_capture_pkg::TB_SYSTEM_CLOCK)
        begin
            t = 1'b1;
        end
        else if (sel <= input_capture_pkg::TB_LAST_TIMER)
        begin
            t = ticks[sel];
        end
        return t;
    endfunction

    // pin synchroniser, first flop read only by second
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
            pin_prev <= 1'b0;
        end
        else if (clk_en)
        begin
            pin_meta <= capture_input_pin;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    assign rise = pin_sync & ~pin_prev;
    assign fall = ~pin_sync & pin_prev;

    // operating mode
    assign cascade_even = EVEN_MODULE && control_two.cascade_enable;
    assign trig_eff = control_two.trigger_mode_select && !cascade_even;
    always_comb
    begin
        if (control_two.sync_source_select == input_capture_pkg::SYNC_NONE)
        begin
            op_mode = trig_eff ? input_capture_pkg::OP_SOFT_TRIGGER
                               : input_capture_pkg::OP_FREE;
        end
        else
        begin
            op_mode = trig_eff ? input_capture_pkg::OP_TRIGGER
                               : input_capture_pkg::OP_SYNC;
        end
    end

    assign sel_sync = (control_two.sync_source_select != input_capture_pkg::SYNC_NONE)
                      && sync_event[control_two.sync_source_select];
    assign tick = base_tick(control_one.time_base_select, timer_tick);
    assign inc = cascade_even ? carry_in : tick;
    assign halted = control_one.idle_stop && cpu_idle;
    assign active = (control_one.capture_mode_select != input_capture_pkg::MODE_OFF)
                    && (control_one.capture_mode_select != input_capture_pkg::MODE_UNUSED)
                    && (control_one.capture_mode_select != input_capture_pkg::MODE_WAKE_PIN)
                    && !halted;

    // counter allowed to run
    always_comb
    begin
        gate = 1'b1;
        case (op_mode)
            input_capture_pkg::OP_TRIGGER, input_capture_pkg::OP_SOFT_TRIGGER:
                gate = control_two.trigger_run_status;
            input_capture_pkg::OP_SYNC:
                gate = !(control_two.cascade_enable
                         && !sync_source_on[control_two.sync_source_select]);
            default:
                gate = 1'b1;
        endcase
        if (cascade_even)
        begin
            gate = gate && partner_run;
        end
    end

    assign carry_out = gate && active && inc && (capture_counter == ALL_ONES);
    assign run_out = gate && active;

    // private counter
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            capture_counter <= '0;
        end
        else if (clk_en)
        begin
            if (!gate)
            begin
                capture_counter <= '0;
            end
            else if (op_mode == input_capture_pkg::OP_SYNC && sel_sync)
            begin
                capture_counter <= '0;
            end
            else if (active && inc)
            begin
                capture_counter <= capture_counter + 1'b1;
            end
        end
    end

    // edge selection and prescaler
    always_comb
    begin
        edge_hit = 1'b0;
        case (control_one.capture_mode_select)
            input_capture_pkg::MODE_EVERY_EDGE:
                edge_hit = rise | fall;
            input_capture_pkg::MODE_FALLING:
                edge_hit = fall;
            input_capture_pkg::MODE_RISING:
                edge_hit = rise;
            input_capture_pkg::MODE_RISE_DIV4:
                edge_hit = rise && prescale == input_capture_pkg::PRESCALE_DIV4_LAST;
            input_capture_pkg::MODE_RISE_DIV16:
                edge_hit = rise && prescale == input_capture_pkg::PRESCALE_DIV16_LAST;
            default:
                edge_hit = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prescale <= 4'h0;
        end
        else if (clk_en)
        begin
            if (!active)
            begin
                prescale <= 4'h0;
            end
            else if (rise)
            begin
                prescale <= edge_hit ? 4'h0 : prescale + 4'h1;
            end
        end
    end

    assign capture_now = (cascade_even ? partner_capture : edge_hit) && active && gate;
    assign capture_strobe = capture_now;

    // apb decode
    assign apb_setup = psel && !penable;
    assign apb_write = psel && penable && pwrite && clk_en;
    assign pready = clk_en;
    assign mapped = (paddr == input_capture_pkg::ADDR_CONTROL_ONE)
                    || (paddr == input_capture_pkg::ADDR_CONTROL_TWO)
                    || (paddr == input_capture_pkg::ADDR_BUFFER);
    assign pslverr = psel && penable && !mapped;
    assign push = capture_now && (fill != FULL_COUNT);
    assign pop = psel && penable && !pwrite && clk_en
                 && paddr == input_capture_pkg::ADDR_BUFFER && fill != '0;

    // capture FIFO
    always_ff @(posedge pclk)
    begin
        if (clk_en && push)
        begin
            fifo_mem[wr_ptr] <= capture_counter;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill <= '0;
        end
        else if (clk_en)
        begin
            if (push)
            begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop)
            begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop)
            begin
                fill <= fill + 1'b1;
            end
            else if (pop && !push)
            begin
                fill <= fill - 1'b1;
            end
        end
    end

    // overflow flag, cleared only by turning the module off
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            overflow <= 1'b0;
        end
        else if (clk_en)
        begin
            if (capture_now && fill == FULL_COUNT)
            begin
                overflow <= 1'b1;
            end
            else if (control_one.capture_mode_select == input_capture_pkg::MODE_OFF)
            begin
                overflow <= 1'b0;
            end
        end
    end

    // interrupt decimation and wake pin
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            event_count <= 2'h0;
            capture_irq <= 1'b0;
        end
        else if (clk_en)
        begin
            capture_irq <= 1'b0;
            if (control_one.capture_mode_select == input_capture_pkg::MODE_WAKE_PIN)
            begin
                event_count <= 2'h0;
                capture_irq <= rise && (cpu_sleep || cpu_idle);
            end
            else if (!active)
            begin
                event_count <= 2'h0;
            end
            else if (capture_now)
            begin
                if (control_one.capture_mode_select == input_capture_pkg::MODE_EVERY_EDGE
                    || event_count == control_one.captures_per_interrupt)
                begin
                    event_count <= 2'h0;
                    capture_irq <= 1'b1;
                end
                else
                begin
                    event_count <= event_count + 2'h1;
                end
            end
        end
    end

    // control registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            control_one <= input_capture_pkg::CONTROL_ONE_RESET;
        end
        else if (apb_write && paddr == input_capture_pkg::ADDR_CONTROL_ONE)
        begin
            control_one <= pwdata[15:0] & input_capture_pkg::CONTROL_ONE_WMASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            control_two <= input_capture_pkg::CONTROL_TWO_RESET;
        end
        else if (clk_en)
        begin
            if (apb_write && paddr == input_capture_pkg::ADDR_CONTROL_TWO)
            begin
                control_two <= pwdata[15:0] & input_capture_pkg::CONTROL_TWO_WMASK;
            end
            if (op_mode == input_capture_pkg::OP_TRIGGER && sel_sync)
            begin
                control_two.trigger_run_status <= 1'b1;
            end
        end
    end

    // read data, loaded in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (clk_en && apb_setup && !pwrite)
        begin
            if (paddr == input_capture_pkg::ADDR_CONTROL_ONE)
            begin
                prdata <= {16'h0000, control_one[15:5], overflow, fill != '0,
                           control_one.capture_mode_select};
            end
            else if (paddr == input_capture_pkg::ADDR_CONTROL_TWO)
            begin
                prdata <= {16'h0000, control_two};
            end
            else if (paddr == input_capture_pkg::ADDR_BUFFER && fill != '0)
            begin
                prdata <= {16'h0000, fifo_mem[rd_ptr]};
            end
            else
            begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    AST_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && gate && active && inc && capture_counter == ALL_ONES
        && !(op_mode == input_capture_pkg::OP_SYNC && sel_sync) |=> capture_counter == '0)
        else $error("counter did not wrap to zero");

    AST_PUSH_VALUE: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && push |=> fifo_mem[$past(wr_ptr)] == $past(capture_counter))
        else $error("captured value differs from counter");

    AST_SYNC_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && op_mode == input_capture_pkg::OP_SYNC && sel_sync |=> capture_counter == '0)
        else $error("sync event did not clear counter");

    AST_HELD_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && !gate |=> capture_counter == '0 ##1 (!clk_en || !$past(gate)
        || $past(capture_counter) <= 1))
        else $error("counter ran while held");

    AST_FULL_DROP: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && capture_now && fill == FULL_COUNT && !pop
        |=> overflow && fill == FULL_COUNT && $stable(wr_ptr))
        else $error("capture into full FIFO not dropped");

    AST_DRAIN: assert property (@(posedge pclk) disable iff (!presetn)
        fill == 1 && pop && !push |=> fill == '0 ##1 (fill == '0 || $past(push)))
        else $error("FIFO not empty after last read");

    AST_IRQ_EVERY: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && capture_now && control_one.captures_per_interrupt == 2'h0
        && control_one.capture_mode_select != input_capture_pkg::MODE_WAKE_PIN |=> capture_irq)
        else $error("missing interrupt for capture");

    AST_IDLE_HALT: assert property (@(posedge pclk) disable iff (!presetn)
        halted && control_one.capture_mode_select != input_capture_pkg::MODE_WAKE_PIN
        |-> !push ##1 !capture_irq)
        else $error("capture while halted in idle");

    AST_RESERVED_BASE: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && !cascade_even && gate && op_mode != input_capture_pkg::OP_SYNC
        && control_one.time_base_select > input_capture_pkg::TB_LAST_TIMER
        && control_one.time_base_select != input_capture_pkg::TB_SYSTEM_CLOCK
        |=> $stable(capture_counter))
        else $error("counter moved on reserved time base");

endmodule

// ===== pulse_source.sv
`timescale 1ns/1ps
module pulse_source (
    // clock
    input wire logic pclk,
    // capture pin
    output logic pin
);
    // idle low between pulses; the pin is always driven
    initial pin = 1'b0;

    // n pulses, hi cycles high then lo cycles low; entered just after an edge
    task automatic send(input int n, input int hi, input int lo);
        repeat (n)
        begin
            pin <= 1'b1;
            repeat (hi) @(posedge pclk);
            pin <= 1'b0;
            repeat (lo) @(posedge pclk);
        end
    endtask
endmodule

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic pin;
    logic [1:0] tick_div;
    logic [4:0] timer_tick;
    logic [31:0] sync_event;
    logic [31:0] sync_on;
    logic cpu_idle;
    logic capture_irq;
    logic strobe;
    logic run;
    logic [31:0] rd;
    logic err;
    int mismatches;
    int samples_checked;
    int irq_count;
    int strobe_count;

    input_capture_unit input_capture_unit_inst (
        .pclk(pclk), .presetn(presetn), .clk_en(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .capture_input_pin(pin), .timer_tick(timer_tick),
        .sync_event(sync_event), .sync_source_on(sync_on),
        .cpu_idle(cpu_idle), .cpu_sleep(1'b0),
        .carry_in(1'b0), .partner_capture(1'b0), .partner_run(1'b0),
        .carry_out(), .capture_strobe(strobe), .run_out(run), .capture_irq(capture_irq)
    );

    pulse_source pulse_source_inst (.pclk(pclk), .pin(pin));

    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // every general timer ticks once in four cycles
    always @(posedge pclk)
    begin
        tick_div <= tick_div + 2'h1;
        timer_tick <= {5{tick_div == 2'h3}};
        if (capture_irq === 1'b1)
            irq_count <= irq_count + 1;
        if (strobe === 1'b1)
            strobe_count <= strobe_count + 1;
    end

    task automatic finish_test();
        if (mismatches == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            mismatches++;
            finish_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic set1(input logic [15:0] d);
        apb(1'b1, input_capture_pkg::ADDR_CONTROL_ONE, {16'h0000, d});
    endtask

    task automatic set2(input logic [15:0] d);
        apb(1'b1, input_capture_pkg::ADDR_CONTROL_TWO, {16'h0000, d});
    endtask

    task automatic get1();
        apb(1'b0, input_capture_pkg::ADDR_CONTROL_ONE, 32'h0);
    endtask

    task automatic get2();
        apb(1'b0, input_capture_pkg::ADDR_CONTROL_TWO, 32'h0);
    endtask

    task automatic pop();
        apb(1'b0, input_capture_pkg::ADDR_BUFFER, 32'h0);
    endtask

    // pops until the not-empty flag clears; n is the number popped
    task automatic drain(output int n);
        n = 0;
        get1();
        while (rd[3] === 1'b1 && n < 8)
        begin
            pop();
            n++;
            get1();
        end
    endtask

    task automatic fire_sync();
        sync_event <= 32'h0000_0008;
        @(posedge pclk);
        sync_event <= 32'h0;
    endtask

    task automatic test_registers();
        get1();
        check(rd, 32'h0);
        get2();
        check(rd, 32'h0);
        pop();
        check(rd, 32'h0);
        apb(1'b0, 8'h0C, 32'h0);
        check({31'h0, err}, 32'h1);
        set1(16'hFFFF);
        get1();
        check(rd, 32'h0000_3C67);
        set2(16'hFFFF);
        get2();
        check(rd, 32'h0000_01DF);
        set2(16'h0000);
        set1(16'h0000);
    endtask

    task automatic test_fifo();
        logic [15:0] prev;
        int base;
        set2(16'h0000);
        set1(16'h1C03);
        base = strobe_count;
        pulse_source_inst.send(5, 4, 12);
        check(strobe_count - base, 32'h5);
        get1();
        check(rd, 32'h0000_1C1B);
        pop();
        prev = rd[15:0];
        repeat (3)
        begin
            pop();
            check({16'h0, rd[15:0] - prev}, 32'h10);
            prev = rd[15:0];
        end
        get1();
        check(rd, 32'h0000_1C13);
        pop();
        check(rd, 32'h0);
        set1(16'h0000);
        get1();
        check(rd, 32'h0);
    endtask

    task automatic test_modes();
        logic [2:0] m [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
        int np [6] = '{2, 2, 2, 8, 16, 2};
        int ex [6] = '{4, 2, 2, 2, 1, 0};
        int n;
        for (int i = 0; i < 6; i++)
        begin
            drain(n);
            set1({13'h0380, m[i]});
            pulse_source_inst.send(np[i], 4, 8);
            drain(n);
            check(n, ex[i]);
            set1(16'h0000);
        end
    endtask

    task automatic test_irq();
        logic [1:0] c [5] = '{2'h0, 2'h1, 2'h3, 2'h3, 2'h2};
        logic [2:0] m [5] = '{3'h3, 3'h3, 3'h3, 3'h1, 3'h3};
        int np [5] = '{4, 4, 4, 2, 4};
        int ex [5] = '{4, 2, 1, 4, 1};
        int base;
        for (int i = 0; i < 5; i++)
        begin
            set1({3'h0, 3'h7, 3'h0, c[i], 2'h0, m[i]});
            base = irq_count;
            pulse_source_inst.send(np[i], 4, 8);
            check(irq_count - base, ex[i]);
        end
        set1(16'h0000);
    endtask

    task automatic test_trigger();
        logic [15:0] prev;
        int n;
        drain(n);
        set2(16'h0080);
        set1(16'h1C03);
        pulse_source_inst.send(1, 4, 8);
        pop();
        check(rd, 32'h0);
        set2(16'h00C0);
        get2();
        check(rd, 32'h0000_00C0);
        pulse_source_inst.send(2, 4, 12);
        pop();
        prev = rd[15:0];
        pop();
        check({16'h0, rd[15:0] - prev}, 32'h10);
        check({31'h0, prev == 16'h0}, 32'h0);
        set1(16'h0000);
        drain(n);
        set2(16'h0083);
        sync_on <= 32'h0000_0008;
        set1(16'h1C03);
        pulse_source_inst.send(1, 4, 8);
        pop();
        check(rd, 32'h0);
        fire_sync();
        get2();
        check(rd, 32'h0000_00C3);
        pulse_source_inst.send(1, 4, 8);
        pop();
        check({31'h0, rd == 32'h0}, 32'h0);
        set1(16'h0000);
        set2(16'h0003);
        set1(16'h1C03);
        pulse_source_inst.send(1, 4, 36);
        fire_sync();
        pulse_source_inst.send(1, 4, 8);
        pop();
        pop();
        check({31'h0, rd[15:0] < 16'h10}, 32'h1);
        set1(16'h0000);
        set2(16'h0000);
    endtask

    // odd unit of a pair: held until the sync source is switched on
    task automatic test_cascade();
        int n;
        drain(n);
        sync_on <= 32'h0;
        set2(16'h0103);
        set1(16'h1C03);
        pulse_source_inst.send(1, 4, 8);
        drain(n);
        check(n, 32'h0);
        check({31'h0, run}, 32'h0);
        sync_on <= 32'h0000_0008;
        pulse_source_inst.send(1, 4, 8);
        check({31'h0, run}, 32'h1);
        drain(n);
        check(n, 32'h1);
        set1(16'h0000);
        set2(16'h0000);
    endtask

    task automatic test_idle_timebase();
        logic [15:0] prev;
        int n;
        int base;
        drain(n);
        cpu_idle <= 1'b1;
        set1(16'h3C03);
        pulse_source_inst.send(1, 4, 8);
        drain(n);
        check(n, 32'h0);
        set1(16'h1C03);
        pulse_source_inst.send(1, 4, 8);
        drain(n);
        check(n, 32'h1);
        set1(16'h0007);
        base = irq_count;
        pulse_source_inst.send(1, 4, 8);
        check(irq_count - base, 32'h1);
        cpu_idle <= 1'b0;
        base = irq_count;
        pulse_source_inst.send(1, 4, 8);
        check(irq_count - base, 32'h0);
        set1(16'h0000);
        drain(n);
        set1(16'h0003);
        pulse_source_inst.send(2, 4, 28);
        pop();
        prev = rd[15:0];
        pop();
        check({16'h0, rd[15:0] - prev}, 32'h8);
    endtask

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        tick_div = 2'h0;
        timer_tick = 5'h00;
        sync_event = 32'h0;
        sync_on = 32'h0;
        cpu_idle = 1'b0;
        mismatches = 0;
        samples_checked = 0;
        irq_count = 0;
        strobe_count = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        test_registers();
        test_fifo();
        test_modes();
        test_irq();
        test_trigger();
        test_cascade();
        test_idle_timebase();
        finish_test();
    end
endmodule
